//--- core/gpb_pkg.sv
// constants and types shared by the port, buzzer and power logic
package gpb_pkg;
  localparam int PIN_COUNT = 18;
  localparam int PORT_COUNT = 3;
  localparam int NIBBLE_W = 4;
  localparam int SIX_W = 6;
  localparam int BYTE_W = 8;
  localparam int BYTE_LSB = 10;
  localparam int BUZZ_PIN0 = 4;
  localparam int BUZZ_PIN1 = 5;
  localparam int EXT_PIN = 6;
  localparam logic [17:0] LCD_SHARE_ALLOWED = 18'h0038f;
  localparam logic [7:0] PORT_MASK [PORT_COUNT] = '{8'h0f, 8'h3f, 8'hff};

  localparam int APB_ADDR_W = 12;
  localparam int REG_COUNT_PORT = 9;
  localparam logic [7:0] IDX_PORT_LAST = 8'h08;
  localparam logic [7:0] IDX_STOP = 8'h09;
  localparam logic [7:0] IDX_PIN_NIBBLE = 8'h0a;
  localparam logic [7:0] IDX_PIN_SIX = 8'h0b;
  localparam logic [7:0] IDX_PIN_BYTE = 8'h0c;
  localparam logic [7:0] IDX_INT_STATUS = 8'h10;
  localparam logic [7:0] IDX_INT_MASK = 8'h11;
  localparam logic [7:0] IDX_BUZZ_CTRL = 8'h16;
  localparam logic [7:0] IDX_BUZZ_RELOAD = 8'h17;
  localparam logic [7:0] IDX_WAKE_CAUSE = 8'h18;

  localparam logic [7:0] PORT_DATA_RESET = 8'hff;
  localparam logic [7:0] PORT_DIR_RESET = 8'h00;
  localparam logic [7:0] PORT_ATTR_RESET = 8'h00;
  localparam logic [7:0] STOP_RESET = 8'h00;
  localparam logic [7:0] BUZZ_CTRL_RESET = 8'h00;
  localparam int BUZZ_RELOAD_W = 16;
  localparam logic [15:0] BUZZ_RELOAD_RESET = 16'h00ff;
  localparam logic [17:0] PAD_OEN_RESET = 18'h3ffff;

  localparam int BUZZ_EN_LO = 0;
  localparam int BUZZ_EN_HI = 1;

  localparam int WAKE_COUNT = 5;
  localparam int WAKE_PORT = 0;
  localparam int WAKE_FAST = 1;
  localparam int WAKE_SLOW = 2;
  localparam int WAKE_T128 = 3;
  localparam int WAKE_TIMER = 4;

  localparam int INT_COUNT = 3;
  localparam int INT_EXT = 0;
  localparam int INT_WAKE = 1;
  localparam int INT_BUZZ = 2;

  localparam logic [2:0] MODE_IN_PULLDOWN = 3'b000;
  localparam logic [2:0] MODE_IN_PLAIN = 3'b001;
  localparam logic [2:0] MODE_OUT_LOW = 3'b010;
  localparam logic [2:0] MODE_OUT_HIGH = 3'b011;
  localparam logic [2:0] MODE_FLOAT = 3'b110;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STANDBY = 2'b01,
    ST_WAKE = 2'b11
  } gpb_power_e;
endpackage

//--- core/gpb_buzz_if.sv
// link between the port logic and the buzzer counter
`timescale 1ns/1ps
interface gpb_buzz_if;
  logic enable;
  logic [15:0] reload;
  logic tone;
  logic overflow;
  modport ctrl(output enable, output reload, input tone, input overflow);
  modport buzzer(input enable, input reload, output tone, output overflow);
endinterface

//--- core/gpb_buzzer.sv
// buzzer tone counter, toggles its level on every overflow
`timescale 1ns/1ps
module gpb_buzzer
  import gpb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  gpb_buzz_if.buzzer bz
);
  logic [BUZZ_RELOAD_W-1:0] count;
  logic [BUZZ_RELOAD_W-1:0] next_count;
  logic tone;
  logic next_tone;
  logic overflow;
  logic next_overflow;

  always_comb begin
    next_count = count;
    next_tone = tone;
    next_overflow = 1'b0;
    if (!bz.enable) begin
      // idle low so the pins start from a known phase
      next_count = '0;
      next_tone = 1'b0;
    end else if (count == bz.reload) begin
      next_count = '0;
      next_tone = ~tone;
      next_overflow = 1'b1;
    end else begin
      next_count = BUZZ_RELOAD_W'(count + 16'h0001);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= '0;
      tone <= 1'b0;
      overflow <= 1'b0;
    end else begin
      count <= next_count;
      tone <= next_tone;
      overflow <= next_overflow;
    end
  end

  assign bz.tone = tone;
  assign bz.overflow = overflow;
endmodule

//--- core/gpb_gpio_top.sv
// three-port pin logic with buzzer, external interrupt and standby wake-up
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module gpb_gpio_top
  import gpb_pkg::*;
#(
  parameter logic [17:0] LCD_SHARE = 18'h00000
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NIBBLE_W-1:0] portNibbleIn,
  output logic [NIBBLE_W-1:0] portNibbleOut,
  output logic [NIBBLE_W-1:0] portNibbleOeN,
  output logic [NIBBLE_W-1:0] portNibblePullDown,
  input wire logic [SIX_W-1:0] portSixIn,
  output logic [SIX_W-1:0] portSixOut,
  output logic [SIX_W-1:0] portSixOeN,
  output logic [SIX_W-1:0] portSixPullDown,
  input wire logic [BYTE_W-1:0] portByteIn,
  output logic [BYTE_W-1:0] portByteOut,
  output logic [BYTE_W-1:0] portByteOeN,
  output logic [BYTE_W-1:0] portBytePullDown,
  input wire logic [6:0] lcdSegment,
  input wire logic timeBaseFastTick,
  input wire logic timeBaseSlowTick,
  input wire logic tick128,
  input wire logic timerOverflow,
  output logic cpuHalt,
  output logic cpuWake,
  output logic irq
);
  logic [7:0] portReg [REG_COUNT_PORT];
  logic [7:0] next_portReg [REG_COUNT_PORT];
  logic [7:0] stopReg;
  logic [7:0] next_stopReg;
  logic [7:0] buzzCtrl;
  logic [7:0] next_buzzCtrl;
  logic [BUZZ_RELOAD_W-1:0] buzzReload;
  logic [BUZZ_RELOAD_W-1:0] next_buzzReload;
  logic [INT_COUNT-1:0] intStatus;
  logic [INT_COUNT-1:0] next_intStatus;
  logic [INT_COUNT-1:0] intMask;
  logic [INT_COUNT-1:0] next_intMask;
  logic [WAKE_COUNT-1:0] wakeCause;
  logic [WAKE_COUNT-1:0] next_wakeCause;
  logic [BYTE_W-1:0] byteSnap;
  logic [BYTE_W-1:0] next_byteSnap;
  gpb_power_e powerState;
  gpb_power_e next_powerState;
  logic [PIN_COUNT-1:0] padSync1;
  logic [PIN_COUNT-1:0] padSync2;
  logic extDelay;
  logic [31:0] next_prdata;
  logic [PIN_COUNT-1:0] padOut;
  logic [PIN_COUNT-1:0] padOeN;
  logic [PIN_COUNT-1:0] padPull;
  logic [PIN_COUNT-1:0] next_padOut;
  logic [PIN_COUNT-1:0] next_padOeN;
  logic [PIN_COUNT-1:0] next_padPull;
  logic [PIN_COUNT-1:0] padIn;
  logic [PIN_COUNT-1:0] dataVec;
  logic [PIN_COUNT-1:0] dirVec;
  logic [PIN_COUNT-1:0] attrVec;
  logic [PIN_COUNT-1:0] segVec;
  logic [7:0] regIndex;
  logic addrOk;
  logic mapped;
  logic setupPhase;
  logic accessPhase;
  logic wrEn;
  logic stopWrite;
  logic buzzOn;
  logic extFall;
  logic [WAKE_COUNT-1:0] wakeHit;
  gpb_buzz_if buzzBus ();

  // pins flattened: nibble 0..3, six-bit 4..9, byte 10..17
  assign padIn = {portByteIn, portSixIn, portNibbleIn};
  assign dataVec = {portReg[6], portReg[3][SIX_W-1:0], portReg[0][NIBBLE_W-1:0]};
  assign dirVec = {portReg[7], portReg[4][SIX_W-1:0], portReg[1][NIBBLE_W-1:0]};
  assign attrVec = {portReg[8], portReg[5][SIX_W-1:0], portReg[2][NIBBLE_W-1:0]};
  assign segVec = {8'h00, lcdSegment[6:4], 3'b000, lcdSegment[3:0]};

  // bus decode
  assign regIndex = paddr[9:2];
  assign addrOk = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  always_comb begin
    unique case (regIndex)
      IDX_STOP, IDX_PIN_NIBBLE, IDX_PIN_SIX, IDX_PIN_BYTE, IDX_INT_STATUS,
      IDX_INT_MASK, IDX_BUZZ_CTRL, IDX_BUZZ_RELOAD, IDX_WAKE_CAUSE: mapped = addrOk;
      default: mapped = addrOk && (regIndex <= IDX_PORT_LAST);
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~mapped;
  assign wrEn = accessPhase & pwrite & mapped;
  assign stopWrite = wrEn && (regIndex == IDX_STOP);

  // events; edge detect looks only at second sync stage
  assign extFall = extDelay & ~padSync2[EXT_PIN];
  assign wakeHit[WAKE_PORT] =
    |((padSync2[PIN_COUNT-1:BYTE_LSB] ^ byteSnap) & ~dirVec[PIN_COUNT-1:BYTE_LSB]);
  assign wakeHit[WAKE_FAST] = timeBaseFastTick;
  assign wakeHit[WAKE_SLOW] = timeBaseSlowTick;
  assign wakeHit[WAKE_T128] = tick128;
  assign wakeHit[WAKE_TIMER] = timerOverflow;

  // register file
  always_comb begin
    for (int i = 0; i < REG_COUNT_PORT; i++) begin
      next_portReg[i] = portReg[i];
      if (wrEn && (regIndex == 8'(i))) begin
        next_portReg[i] = pwdata[7:0] & PORT_MASK[i/3];
      end
    end
    next_stopReg = stopReg;
    next_byteSnap = byteSnap;
    if (stopWrite) begin
      next_stopReg = pwdata[7:0];
      next_byteSnap = padSync2[PIN_COUNT-1:BYTE_LSB];
    end
    next_buzzCtrl = buzzCtrl;
    if (wrEn && (regIndex == IDX_BUZZ_CTRL)) begin
      next_buzzCtrl = pwdata[7:0];
    end
    next_buzzReload = buzzReload;
    if (wrEn && (regIndex == IDX_BUZZ_RELOAD)) begin
      next_buzzReload = pwdata[BUZZ_RELOAD_W-1:0];
    end
    next_intMask = intMask;
    if (wrEn && (regIndex == IDX_INT_MASK)) begin
      next_intMask = pwdata[INT_COUNT-1:0];
    end
    next_intStatus = intStatus;
    if (wrEn && (regIndex == IDX_INT_STATUS)) begin
      next_intStatus = intStatus & ~pwdata[INT_COUNT-1:0];
    end
    // sets applied after the clear so a same-cycle event survives
    next_intStatus[INT_EXT] = next_intStatus[INT_EXT] | extFall;
    next_intStatus[INT_WAKE] = next_intStatus[INT_WAKE] | (powerState == ST_WAKE);
    next_intStatus[INT_BUZZ] = next_intStatus[INT_BUZZ] | buzzBus.overflow;
    next_wakeCause = wakeCause;
    if ((powerState == ST_STANDBY) && |(wakeHit & stopReg[WAKE_COUNT-1:0])) begin
      next_wakeCause = wakeHit & stopReg[WAKE_COUNT-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < REG_COUNT_PORT; i++) begin
        unique case (i % 3)
          0: portReg[i] <= PORT_DATA_RESET & PORT_MASK[i/3];
          1: portReg[i] <= PORT_DIR_RESET;
          default: portReg[i] <= PORT_ATTR_RESET;
        endcase
      end
      stopReg <= STOP_RESET;
      byteSnap <= '0;
      buzzCtrl <= BUZZ_CTRL_RESET;
      buzzReload <= BUZZ_RELOAD_RESET;
      intMask <= '0;
      intStatus <= '0;
      wakeCause <= '0;
    end else begin
      portReg <= next_portReg;
      stopReg <= next_stopReg;
      byteSnap <= next_byteSnap;
      buzzCtrl <= next_buzzCtrl;
      buzzReload <= next_buzzReload;
      intMask <= next_intMask;
      intStatus <= next_intStatus;
      wakeCause <= next_wakeCause;
    end
  end

  // power state: standby only gates the processor; port state is never touched
  always_comb begin
    next_powerState = powerState;
    unique case (powerState)
      ST_RUN: begin
        if (stopWrite) begin
          next_powerState = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        // no armed source means no way out but reset
        if (|(wakeHit & stopReg[WAKE_COUNT-1:0])) begin
          next_powerState = ST_WAKE;
        end
      end
      ST_WAKE: next_powerState = ST_RUN;
      default: next_powerState = ST_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      powerState <= ST_RUN;
    end else begin
      powerState <= next_powerState;
    end
  end

  // clock is only released, not restarted, so execution carries on
  assign cpuHalt = (powerState == ST_STANDBY);
  assign cpuWake = (powerState == ST_WAKE);
  assign irq = |(intStatus & intMask);

  // pin synchronisers
  always_ff @(posedge mclk) begin
    if (reset) begin
      padSync1 <= '0;
      padSync2 <= '0;
      extDelay <= 1'b0;
    end else begin
      padSync1 <= padIn;
      padSync2 <= padSync1;
      extDelay <= padSync2[EXT_PIN];
    end
  end

  // read data captured in the setup phase, stands through the access phase
  always_comb begin
    next_prdata = prdata;
    if (setupPhase && !pwrite) begin
      next_prdata = '0;
      if (mapped) begin
        if (regIndex <= IDX_PORT_LAST) begin
          next_prdata[7:0] = portReg[regIndex[3:0]];
        end else begin
          unique case (regIndex)
            IDX_STOP: next_prdata[7:0] = stopReg;
            IDX_PIN_NIBBLE: next_prdata[NIBBLE_W-1:0] = padSync2[3:0];
            IDX_PIN_SIX: next_prdata[SIX_W-1:0] = padSync2[9:4];
            IDX_PIN_BYTE: next_prdata[BYTE_W-1:0] = padSync2[17:10];
            IDX_INT_STATUS: next_prdata[INT_COUNT-1:0] = intStatus;
            IDX_INT_MASK: next_prdata[INT_COUNT-1:0] = intMask;
            IDX_BUZZ_CTRL: next_prdata[7:0] = buzzCtrl;
            IDX_BUZZ_RELOAD: next_prdata[BUZZ_RELOAD_W-1:0] = buzzReload;
            IDX_WAKE_CAUSE: next_prdata[WAKE_COUNT-1:0] = wakeCause;
            default: next_prdata = '0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end

  // buzzer counter
  assign buzzOn = buzzCtrl[BUZZ_EN_HI] & buzzCtrl[BUZZ_EN_LO];
  assign buzzBus.enable = buzzOn;
  assign buzzBus.reload = buzzReload;

  gpb_buzzer uBuzzer (
    .mclk(mclk),
    .reset(reset),
    .bz(buzzBus.buzzer)
  );

  // returns {out, oeN, pullDown}; undefined codes fall back to plain input
  function automatic logic [2:0] padDrive(input logic attr, input logic dir,
                                          input logic data);
    unique case ({attr, dir, data})
      MODE_IN_PULLDOWN: padDrive = 3'b011;
      MODE_OUT_LOW: padDrive = 3'b000;
      MODE_OUT_HIGH: padDrive = 3'b100;
      MODE_IN_PLAIN, MODE_FLOAT: padDrive = 3'b010;
      default: padDrive = 3'b010;
    endcase
  endfunction

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    if (LCD_SHARE[i] && LCD_SHARE_ALLOWED[i]) begin : g_seg
      assign {next_padOut[i], next_padOeN[i], next_padPull[i]} =
        {segVec[i], 2'b00};
    end else if ((i == BUZZ_PIN0) || (i == BUZZ_PIN1)) begin : g_buzz
      assign {next_padOut[i], next_padOeN[i], next_padPull[i]} = buzzOn ?
        {buzzBus.tone, 2'b00} : padDrive(attrVec[i], dirVec[i], dataVec[i]);
    end else begin : g_io
      assign {next_padOut[i], next_padOeN[i], next_padPull[i]} =
        padDrive(attrVec[i], dirVec[i], dataVec[i]);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      padOut <= '0;
      padOeN <= PAD_OEN_RESET;
      padPull <= '0;
    end else begin
      padOut <= next_padOut;
      padOeN <= next_padOeN;
      padPull <= next_padPull;
    end
  end

  assign portNibbleOut = padOut[3:0];
  assign portNibbleOeN = padOeN[3:0];
  assign portNibblePullDown = padPull[3:0];
  assign portSixOut = padOut[9:4];
  assign portSixOeN = padOeN[9:4];
  assign portSixPullDown = padPull[9:4];
  assign portByteOut = padOut[17:10];
  assign portByteOeN = padOeN[17:10];
  assign portBytePullDown = padPull[17:10];
endmodule

//--- sim/gpb_gpio_properties.sv
// assertion checker for the port, buzzer and standby logic
`timescale 1ns/1ps
module gpb_gpio_checker
  import gpb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [SIX_W-1:0] portSixIn,
  input wire logic [SIX_W-1:0] portSixOut,
  input wire logic [SIX_W-1:0] portSixOeN,
  input wire logic [NIBBLE_W-1:0] portNibbleOeN,
  input wire logic [BYTE_W-1:0] portByteOut,
  input wire logic [BYTE_W-1:0] portByteOeN,
  input wire logic [BYTE_W-1:0] portBytePullDown,
  input wire logic cpuHalt,
  input wire logic cpuWake,
  input wire logic irq
);
  logic wrEn;
  logic [7:0] byteData, byteDir, byteAttr, byteDrv, bytePull;
  logic [2:0] intMask;
  logic buzzMode;
  logic lastTone;
  logic [15:0] reload;
  logic [16:0] runLen;
  assign wrEn = psel && penable && pwrite;
  assign byteDrv = ~byteAttr & byteDir;
  assign bytePull = ~byteAttr & ~byteDir & ~byteData;
  // shadow copies of the registers the properties depend on
  always_ff @(posedge mclk) begin
    if (reset) begin
      byteData <= PORT_DATA_RESET;
      byteDir <= PORT_DIR_RESET;
      byteAttr <= PORT_ATTR_RESET;
      intMask <= 3'h0;
      buzzMode <= 1'b0;
      reload <= BUZZ_RELOAD_RESET;
    end else if (wrEn) begin
      case (paddr)
        12'h018: byteData <= pwdata[7:0];
        12'h01c: byteDir <= pwdata[7:0];
        12'h020: byteAttr <= pwdata[7:0];
        12'h044: intMask <= pwdata[2:0];
        12'h058: buzzMode <= &pwdata[1:0];
        12'h05c: reload <= pwdata[15:0];
        default: ;
      endcase
    end
  end
  // cycles since the tone last moved; one slack cycle covers the mode switch
  always_ff @(posedge mclk) begin
    lastTone <= portSixOut[0];
    if (!buzzMode || portSixOut[0] != lastTone) begin
      runLen <= 17'h0;
    end else begin
      runLen <= runLen + 17'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  reset_inputs_a: assert property (disable iff (1'b0)
    reset |=> &portNibbleOeN && &portSixOeN && &portByteOeN && portBytePullDown == 8'h00)
    else $error("pins not inputs after reset");
  byte_mode_a: assert property (
    portByteOeN == ~$past(byteDrv) && portBytePullDown == $past(bytePull)
    && ((portByteOut ^ $past(byteData)) & ~portByteOeN) == 8'h00)
    else $error("byte pin mode decode wrong");
  buzz_pins_a: assert property (buzzMode && $past(buzzMode) |->
    portSixOeN[1:0] == 2'b00 && portSixOut[0] == portSixOut[1])
    else $error("buzzer pins not driving one tone");
  buzz_toggles_a: assert property (
    buzzMode |-> runLen <= {1'b0, reload} + 17'h3)
    else $error("buzzer tone stopped toggling");
  stop_halts_a: assert property (
    wrEn && paddr == 12'h024 |=> cpuHalt)
    else $error("stop write did not halt");
  halt_hold_a: assert property (cpuHalt && $past(cpuHalt) |->
    $stable(portByteOut) && $stable(portByteOeN) && $stable(portNibbleOeN)
    && $stable(portSixOeN[5:2]))
    else $error("pins moved in standby");
  wake_pulse_a: assert property (
    cpuWake |-> !cpuHalt && $past(cpuHalt) ##1 !cpuWake && !cpuHalt)
    else $error("wake pulse malformed");
  ext_irq_a: assert property (
    $fell(portSixIn[2]) && intMask[0] |-> ##[2:6] irq)
    else $error("falling external pin gave no irq");
  halt_cov_c: cover property ($rose(cpuHalt));
  wake_cov_c: cover property (cpuWake);
  tone_cov_c: cover property (buzzMode && $changed(portSixOut[0]));
  irq_cov_c: cover property ($rose(irq));
endmodule

bind gpb_gpio_top gpb_gpio_checker gpb_gpio_checker_i (.mclk(mclk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .portSixIn(portSixIn), .portSixOut(portSixOut), .portSixOeN(portSixOeN),
  .portNibbleOeN(portNibbleOeN), .portByteOut(portByteOut), .portByteOeN(portByteOeN),
  .portBytePullDown(portBytePullDown), .cpuHalt(cpuHalt), .cpuWake(cpuWake), .irq(irq));

//--- sim/gpb_pad_model.sv
// pad and key model: resolves each pin from pin drive, key and pull-down
`timescale 1ns/1ps
module gpb_pad_model (
  input wire logic mclk,
  input wire logic [17:0] padOut,
  input wire logic [17:0] padOeN,
  input wire logic [17:0] padPull,
  input wire logic [17:0] keyEn,
  input wire logic [17:0] keyVal,
  output logic [17:0] padLevel
);
  logic floatPat;
  // an open pad holds no level, so it flips every cycle
  initial floatPat = 1'b0;
  always @(posedge mclk) floatPat <= ~floatPat;
  // pin drive wins over a key; pull-down only where nothing drives
  assign padLevel = (~padOeN & padOut) | (padOeN & keyEn & keyVal)
    | (padOeN & ~keyEn & ~padPull & {18{floatPat}});
endmodule

//--- sim/testbench.sv
// self-checking bench for the three-port pin logic
`timescale 1ns/1ps
module testbench;
  import gpb_pkg::*;
  logic mclk, reset, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, cpuHalt, cpuWake, irq;
  logic [17:0] keyEn, keyVal;
  logic [3:0] evt;
  wire [17:0] pOut, pOeN, pPull, pLvl;
  int fail_count = 0;
  int checked = 0;
  // six-bit pins 3..5 become segments; byte pin 0 asks too but may not share
  gpb_gpio_top #(.LCD_SHARE(18'h00780)) gpb_gpio_top_i (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portNibbleIn(pLvl[3:0]), .portNibbleOut(pOut[3:0]),
    .portNibbleOeN(pOeN[3:0]), .portNibblePullDown(pPull[3:0]), .portSixIn(pLvl[9:4]),
    .portSixOut(pOut[9:4]), .portSixOeN(pOeN[9:4]), .portSixPullDown(pPull[9:4]),
    .portByteIn(pLvl[17:10]), .portByteOut(pOut[17:10]), .portByteOeN(pOeN[17:10]),
    .portBytePullDown(pPull[17:10]), .lcdSegment(7'h55), .timeBaseFastTick(evt[0]),
    .timeBaseSlowTick(evt[1]), .tick128(evt[2]), .timerOverflow(evt[3]),
    .cpuHalt(cpuHalt), .cpuWake(cpuWake), .irq(irq));
  gpb_pad_model gpb_pad_model_i (.mclk(mclk), .padOut(pOut), .padOeN(pOeN),
    .padPull(pPull), .keyEn(keyEn), .keyVal(keyVal), .padLevel(pLvl));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("counts: %0d compared, %0d mismatched", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // each transfer starts on a fresh edge so psel never gets two writes in one step
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH pready expected 1 seen %b", pready);
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    xfer(idx, 1'b1, wd, rd, err);
  endtask
  task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] mask,
      input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    xfer(idx, 1'b0, 32'h0, rd, err);
    check(what, exp, rd & mask);
  endtask
  task automatic waitn(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic testReset();
    rdchk("nibble data", 8'h00, 32'hffffffff, 32'h0f);
    rdchk("six data", 8'h03, 32'hffffffff, 32'h3f);
    rdchk("byte data", 8'h06, 32'hffffffff, 32'hff);
    rdchk("byte dir", 8'h07, 32'hffffffff, 32'h0);
    rdchk("six attr", 8'h05, 32'hffffffff, 32'h0);
    waitn(1);
    check("pad enables", 32'h3fc7f, {14'h0, pOeN});
    check("segment pins", 32'h5, {29'h0, pOut[9:7]});
    check("pull downs", 32'h0, {14'h0, pPull});
    wr(8'h01, 32'hff);
    wr(8'h04, 32'hff);
    rdchk("nibble dir width", 8'h01, 32'hffffffff, 32'h0f);
    rdchk("six dir width", 8'h04, 32'hffffffff, 32'h3f);
    waitn(2);
    check("nibble drive high", 32'h0f, {28'h0, pOut[3:0] & ~pOeN[3:0]});
    wr(8'h01, 32'h0);
    wr(8'h04, 32'h0);
    $display("reset test done");
  endtask
  task automatic testModes();
    // byte pins 0..4 take codes 000 001 010 011 110, pins 5..7 pull down
    wr(8'h06, 32'h0a);
    wr(8'h07, 32'h1c);
    wr(8'h08, 32'h10);
    waitn(4);
    check("byte enables", 32'hf3, {24'h0, pOeN[17:10]});
    check("byte pulls", 32'he1, {24'h0, pPull[17:10]});
    check("byte drive", 32'h08, {24'h0, pOut[17:10] & 8'h0c});
    rdchk("byte levels", IDX_PIN_BYTE, 32'hff, 32'h1a);
    $display("mode test done");
  endtask
  task automatic testBuzzer();
    int toggles;
    int split;
    logic prev;
    wr(IDX_BUZZ_RELOAD, 32'h3);
    wr(IDX_BUZZ_CTRL, 32'h3);
    waitn(3);
    check("buzz enables", 32'h0, {30'h0, pOeN[5:4]});
    toggles = 0;
    split = 0;
    prev = pOut[4];
    repeat (40) begin
      @(negedge mclk);
      if (pOut[4] !== prev) toggles++;
      if (pOut[5] !== pOut[4]) split++;
      prev = pOut[4];
    end
    check("tone toggles", 32'h1, {31'h0, toggles >= 9 && toggles <= 11});
    check("tone pins split", 32'h0, split);
    rdchk("overflow status", IDX_INT_STATUS, 32'h4, 32'h4);
    wr(IDX_BUZZ_CTRL, 32'h0);
    wr(8'h03, 32'h02);
    wr(8'h04, 32'h03);
    waitn(2);
    check("normal pins", 32'h2, {30'h0, pOut[5:4] & ~pOeN[5:4]});
    check("normal enables", 32'h0, {30'h0, pOeN[5:4]});
    wr(8'h04, 32'h0);
    wr(8'h03, 32'h3f);
    $display("buzzer test done");
  endtask
  task automatic testExtIrq();
    @(posedge mclk);
    keyEn[6] <= 1'b1;
    keyVal[6] <= 1'b1;
    wr(IDX_INT_MASK, 32'h1);
    wr(IDX_INT_STATUS, 32'h7);
    waitn(1);
    check("irq idle", 32'h0, {31'h0, irq});
    @(posedge mclk);
    keyVal[6] <= 1'b0;
    waitn(8);
    check("irq raised", 32'h1, {31'h0, irq});
    wr(IDX_INT_STATUS, 32'h1);
    waitn(1);
    check("irq cleared", 32'h0, {31'h0, irq});
    @(posedge mclk);
    keyVal[6] <= 1'b1;
    waitn(4);
    wr(IDX_INT_MASK, 32'h0);
    @(posedge mclk);
    keyVal[6] <= 1'b0;
    waitn(8);
    check("irq masked", 32'h0, {31'h0, irq});
    rdchk("ext status", IDX_INT_STATUS, 32'h1, 32'h1);
    wr(IDX_INT_STATUS, 32'h7);
    $display("external pin test done");
  endtask
  task automatic testStandby();
    logic [17:0] oenSnap;
    logic [17:0] outSnap;
    int n;
    @(posedge mclk);
    keyEn[17] <= 1'b1;
    for (int k = 0; k < WAKE_COUNT; k++) begin
      wr(IDX_STOP, 32'h1 << k);
      waitn(4);
      check("halted", 32'h1, {31'h0, cpuHalt});
      oenSnap = pOeN;
      outSnap = pOut;
      @(posedge mclk);
      evt <= (k == 4) ? 4'h4 : 4'h8;
      @(posedge mclk);
      evt <= 4'h0;
      waitn(3);
      check("still halted", 32'h1, {31'h0, cpuHalt});
      @(posedge mclk);
      if (k == 0) keyVal[17] <= ~keyVal[17];
      else evt <= 4'h1 << (k - 1);
      @(posedge mclk);
      evt <= 4'h0;
      n = 0;
      while (cpuWake !== 1'b1 && n < 20) begin
        @(negedge mclk);
        n++;
      end
      if (n >= 20) begin
        fail_count++;
        $display("MISMATCH cpuWake expected 1 seen %b", cpuWake);
        complete_run();
      end
      check("resumed", 32'h0, {31'h0, cpuHalt});
      check("pins kept", {14'h0, oenSnap}, {14'h0, pOeN});
      check("levels kept", {14'h0, outSnap}, {14'h0, pOut});
      rdchk("wake cause", IDX_WAKE_CAUSE, 32'h1 << k, 32'h1 << k);
    end
    rdchk("wake status", IDX_INT_STATUS, 32'h2, 32'h2);
    $display("standby test done");
  endtask
  task automatic testUnmapped();
    logic [31:0] rd;
    logic err;
    xfer(8'h3f, 1'b0, 32'h0, rd, err);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    $display("unmapped test done");
  endtask
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    keyEn = 18'h00012 << 10;
    keyVal = 18'h00012 << 10;
    evt = 4'h0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    testReset();
    testModes();
    testBuzzer();
    testExtIrq();
    testStandby();
    testUnmapped();
    complete_run();
  end
endmodule
